/* common/tsmi_pkg.sv */
// Constants, mode type and decode helpers of the temperature interrupt block.
// Assumes one clock domain and an AHB-Lite slave with word-aligned registers.
package tsmi_pkg;

  localparam int         TSMI_NCH     = 6;
  localparam int         TSMI_TW      = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CH1_HYST = 8'h3a;
  localparam logic [7:0] IDX_SD_EN    = 8'h40;
  localparam logic [7:0] IDX_SRC_A    = 8'h43;
  localparam logic [7:0] IDX_SRC_B    = 8'h44;
  localparam logic [7:0] IDX_SHUT     = 8'h46;
  localparam logic [7:0] IDX_MODE     = 8'h4c;
  localparam logic [7:0] IDX_EXT_EN   = 8'h80;
  localparam logic [7:0] IDX_EXT_MSK  = 8'h81;
  localparam logic [7:0] IDX_STAT     = 8'h82;
  localparam logic [7:0] IDX_IMASK    = 8'h83;
  localparam logic [7:0] IDX_ARMED    = 8'h84;
  localparam logic [7:0] IDX_LIM0     = 8'h90;
  // Field positions
  localparam int         B_SD_EN1     = 4;
  localparam int         B_SRC_A1     = 4;
  localparam int         B_SRC_B3     = 5;
  localparam int         B_SHUT1      = 3;
  localparam int         B_ONESHOT    = 5;
  localparam int         B_CMPSEL     = 6;
  localparam int         B_EXT_SHUT   = 3;
  // Values
  localparam logic [7:0]  HYST_CMP    = 8'h7f;
  localparam logic [15:0] LIM_RST     = 16'h7e7f;
  localparam logic [7:0]  REG_RST     = 8'h00;

  typedef enum logic [1:0] {
    TSMI_OFF = 2'b00,
    TSMI_TWO = 2'b01,
    TSMI_ONE = 2'b11,
    TSMI_CMP = 2'b10
  } tsmi_mode_t;

  // Channel mode from its mask, enable and select bits
  function automatic tsmi_mode_t tsmi_mode(input logic first, input logic src,
                                          input logic en, input logic shut,
                                          input logic cmpsel, input logic oneshot,
                                          input logic [7:0] hyst);
    tsmi_mode_t m;
    m = TSMI_TWO;
    if (src)
      m = TSMI_OFF;
    else if (en)
      m = shut ? TSMI_OFF : TSMI_TWO;
    else if (first && hyst == HYST_CMP)
      m = TSMI_CMP;
    else if (first)
      m = oneshot ? TSMI_ONE : TSMI_TWO;
    else if (cmpsel)
      m = TSMI_CMP;
    return m;
  endfunction : tsmi_mode

endpackage : tsmi_pkg

/* rtl/tsmi_lim_mem.sv */
// Limit memory: one word per channel, high limit low byte, hysteresis high byte.
// Assumes writes and both reads share hclk; read data are registered.
`timescale 1ns/1ps
module tsmi_lim_mem
  import tsmi_pkg::*;
#(
  parameter int DEPTH = TSMI_NCH,
  parameter int AW    = 3
)(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [1:0]    we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [15:0]   wdata,
  input  wire logic [AW-1:0] ra_addr,
  output logic      [15:0]   ra_data,
  input  wire logic [AW-1:0] rb_addr,
  output logic      [15:0]   rb_data
);

  logic [15:0] mem [DEPTH];

  // Byte-lane writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= LIM_RST;
    end
    else
    begin
      if (we[0])
        mem[waddr][7:0] <= wdata[7:0];
      if (we[1])
        mem[waddr][15:8] <= wdata[15:8];
    end
  end

  // Registered read ports
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ra_data <= LIM_RST;
      rb_data <= LIM_RST;
    end
    else
    begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end

endmodule : tsmi_lim_mem

/* rtl/tsmi_chan.sv */
// One temperature channel: armed state and event decision per evaluation.
// Assumes temperature and limits are two's complement and valid with eval.
`timescale 1ns/1ps
module tsmi_chan
  import tsmi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       eval,
  input  tsmi_mode_t      mode,
  input  wire logic [7:0] temp,
  input  wire logic [7:0] hi_lim,
  input  wire logic [7:0] lo_lim,
  output logic            event_p,
  output logic            armed
);

  logic over;
  logic under;
  logic next_armed;
  logic next_event;

  assign over  = $signed(temp) > $signed(hi_lim);
  assign under = $signed(temp) < $signed(lo_lim);

  // Armed bit and event decision
  always_comb
  begin
    next_armed = armed ? !over : under;
    next_event = 1'b0;
    case (mode)
      TSMI_OFF: next_armed = 1'b1;
      TSMI_TWO: next_event = (armed && over) || (!armed && under);
      TSMI_ONE: next_event = armed && over;
      TSMI_CMP: next_event = over || (!armed && !under);
      default:  next_event = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed   <= 1'b1;
      event_p <= 1'b0;
    end
    else
    begin
      event_p <= eval && next_event;
      if (eval)
        armed <= next_armed;
    end
  end

  a_two_rise: assert property (@(posedge clk) disable iff (!rst_n)
    eval && mode == TSMI_TWO && armed && over |=> event_p && !armed)
    else $error("two-times rise not reported");
  a_two_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    eval && mode == TSMI_TWO && !armed && !under |=> !event_p && !armed)
    else $error("repeat event while high");
  a_one_fall: assert property (@(posedge clk) disable iff (!rst_n)
    eval && mode == TSMI_ONE && !armed |=> !event_p)
    else $error("one-time mode reported a fall");
  a_cmp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    eval && mode == TSMI_CMP && (over || (!armed && !under)) |=> event_p)
    else $error("comparator event missing");
  a_rearm_low: assert property (@(posedge clk) disable iff (!rst_n)
    eval && mode != TSMI_OFF && !armed && under |=> armed)
    else $error("channel not re-armed");

endmodule : tsmi_chan

/* rtl/tsmi_ctrl.sv */
// Temperature interrupt controller: AHB-Lite registers, channel scan, status.
// Assumes temperature readings come from logic on hclk; one wait state a transfer.
`timescale 1ns/1ps
module tsmi_ctrl
  import tsmi_pkg::*;
#(
  parameter int NCH = TSMI_NCH
)(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire logic [NCH*8-1:0]  temp_reading,
  output logic                   irq,
  output logic                   mgmt_interrupt_n
);

  // ----------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------

  logic       a_take;
  logic       busy;
  logic       d_write;
  logic       d_hit;
  logic [7:0] d_idx;
  logic [7:0] a_idx;
  logic       wr;
  logic       rd;

  assign a_take = hsel && hready && htrans[1];
  assign a_idx  = haddr[9:2];
  assign wr     = busy && d_write && d_hit;
  assign rd     = busy && !d_write && d_hit;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy    <= 1'b0;
      d_write <= 1'b0;
      d_hit   <= 1'b0;
      d_idx   <= 8'h00;
    end
    else if (a_take)
    begin
      busy    <= 1'b1;
      d_write <= hwrite;
      d_hit   <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
      d_idx   <= a_idx;
    end
    else
    begin
      busy <= 1'b0;
    end
  end

  // One wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      if (a_take)
        hreadyout <= 1'b0;
      else if (busy)
        hreadyout <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  logic [7:0] sd_en_r;
  logic [7:0] src_a_r;
  logic [7:0] src_b_r;
  logic [7:0] shut_r;
  logic [7:0] mode_r;
  logic [7:0] ext_en_r;
  logic [7:0] ext_msk_r;
  logic [7:0] imask;

  // Software writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sd_en_r   <= REG_RST;
      src_a_r   <= REG_RST;
      src_b_r   <= REG_RST;
      shut_r    <= REG_RST;
      mode_r    <= REG_RST;
      ext_en_r  <= REG_RST;
      ext_msk_r <= REG_RST;
      imask     <= REG_RST;
    end
    else if (wr)
    begin
      case (d_idx)
        IDX_SD_EN:   sd_en_r   <= hwdata[7:0];
        IDX_SRC_A:   src_a_r   <= hwdata[7:0];
        IDX_SRC_B:   src_b_r   <= hwdata[7:0];
        IDX_SHUT:    shut_r    <= hwdata[7:0];
        IDX_MODE:    mode_r    <= hwdata[7:0];
        IDX_EXT_EN:  ext_en_r  <= hwdata[7:0];
        IDX_EXT_MSK: ext_msk_r <= hwdata[7:0];
        IDX_IMASK:   imask     <= hwdata[7:0];
        default:     ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Limit memory access
  // ----------------------------------------------------------------

  logic [1:0]  lim_we;
  logic [2:0]  lim_waddr;
  logic [15:0] lim_wdata;
  logic [2:0]  lim_raddr;
  logic [15:0] lim_rdata;
  logic [2:0]  scan;
  logic [2:0]  scan_d;
  logic        scan_v;
  logic [15:0] scan_lim;

  // Is the index inside the per-channel limit window
  function automatic logic lim_win(input logic [7:0] idx);
    return (idx >= IDX_LIM0) && (idx < IDX_LIM0 + 8'(NCH));
  endfunction : lim_win

  // Bus write into limit words or channel 1 hysteresis byte
  always_comb
  begin
    lim_we    = 2'b00;
    lim_waddr = 3'(d_idx - IDX_LIM0);
    lim_wdata = hwdata[15:0];
    if (wr && lim_win(d_idx))
      lim_we = 2'b11;
    else if (wr && d_idx == IDX_CH1_HYST)
    begin
      lim_we    = 2'b10;
      lim_waddr = 3'h0;
      lim_wdata = {hwdata[7:0], 8'h00};
    end
  end

  // Read address taken in the address phase
  assign lim_raddr = (a_idx == IDX_CH1_HYST) ? 3'h0 : 3'(a_idx - IDX_LIM0);

  tsmi_lim_mem #(
    .DEPTH (NCH),
    .AW    (3)
  ) u_mem (
    .clk     (hclk),
    .rst_n   (hresetn),
    .we      (lim_we),
    .waddr   (lim_waddr),
    .wdata   (lim_wdata),
    .ra_addr (lim_raddr),
    .ra_data (lim_rdata),
    .rb_addr (scan),
    .rb_data (scan_lim)
  );

  // ----------------------------------------------------------------
  // Channel scan
  // ----------------------------------------------------------------

  // Round-robin over channels; limits arrive one cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scan   <= 3'h0;
      scan_d <= 3'h0;
      scan_v <= 1'b0;
    end
    else
    begin
      scan   <= (scan == 3'(NCH - 1)) ? 3'h0 : scan + 3'h1;
      scan_d <= scan;
      scan_v <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and channels
  // ----------------------------------------------------------------

  logic [NCH-1:0] src_m;
  logic [NCH-1:0] sd_en;
  logic [NCH-1:0] sd_m;
  logic [NCH-1:0] ev_vec;
  logic [NCH-1:0] armed_vec;
  tsmi_mode_t     ch_mode [NCH];

  assign src_m[0] = src_a_r[B_SRC_A1];
  assign sd_en[0] = sd_en_r[B_SD_EN1];
  assign sd_m[0]  = shut_r[B_SHUT1];
  assign src_m[1] = src_a_r[B_SRC_A1+1];
  assign sd_en[1] = sd_en_r[B_SD_EN1+1];
  assign sd_m[1]  = shut_r[B_SHUT1+1];
  assign src_m[2] = src_b_r[B_SRC_B3];
  assign sd_en[2] = sd_en_r[B_SD_EN1+2];
  assign sd_m[2]  = shut_r[B_SHUT1+2];

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      if (g >= 3)
      begin : g_ext
        // Channels 4 to 6 mode bits
        assign src_m[g] = ext_msk_r[g-3];
        assign sd_en[g] = ext_en_r[g-3];
        assign sd_m[g]  = ext_msk_r[B_EXT_SHUT+g-3];
      end

      assign ch_mode[g] = tsmi_mode(g == 0, src_m[g], sd_en[g], sd_m[g],
                                    mode_r[B_CMPSEL], mode_r[B_ONESHOT],
                                    scan_lim[15:8]);

      tsmi_chan u_ch (
        .clk     (hclk),
        .rst_n   (hresetn),
        .eval    (scan_v && scan_d == 3'(g)),
        .mode    (ch_mode[g]),
        .temp    (temp_reading[g*8 +: 8]),
        .hi_lim  (scan_lim[7:0]),
        .lo_lim  (scan_lim[15:8]),
        .event_p (ev_vec[g]),
        .armed   (armed_vec[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------

  logic [NCH-1:0] stat;
  logic [NCH-1:0] clr;
  logic           next_irq;

  // Read of status or write-one clears; new events win
  always_comb
  begin
    clr = '0;
    if (rd && d_idx == IDX_STAT)
      clr = stat;
    else if (wr && d_idx == IDX_STAT)
      clr = hwdata[NCH-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat <= '0;
    else
      stat <= (stat & ~clr) | ev_vec;
  end

  assign next_irq = |(stat & ~imask[NCH-1:0]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq              <= 1'b0;
      mgmt_interrupt_n <= 1'b1;
    end
    else
    begin
      irq              <= next_irq;
      mgmt_interrupt_n <= !next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Read mux, loaded in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (busy)
    begin
      hrdata <= 32'h00000000;
      if (rd)
      begin
        case (d_idx)
          IDX_CH1_HYST: hrdata[7:0]     <= lim_rdata[15:8];
          IDX_SD_EN:    hrdata[7:0]     <= sd_en_r;
          IDX_SRC_A:    hrdata[7:0]     <= src_a_r;
          IDX_SRC_B:    hrdata[7:0]     <= src_b_r;
          IDX_SHUT:     hrdata[7:0]     <= shut_r;
          IDX_MODE:     hrdata[7:0]     <= mode_r;
          IDX_EXT_EN:   hrdata[7:0]     <= ext_en_r;
          IDX_EXT_MSK:  hrdata[7:0]     <= ext_msk_r;
          IDX_STAT:     hrdata[NCH-1:0] <= stat;
          IDX_IMASK:    hrdata[7:0]     <= imask;
          IDX_ARMED:    hrdata[NCH-1:0] <= armed_vec;
          default:
          begin
            if (lim_win(d_idx))
              hrdata[15:0] <= lim_rdata;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    |(stat & ~imask[NCH-1:0]) |=> irq && !mgmt_interrupt_n)
    else $error("interrupt not raised for pending event");
  a_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat & ~imask[NCH-1:0]) == '0 |=> !irq && mgmt_interrupt_n)
    else $error("interrupt raised with nothing pending");
  a_stat_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    !(busy && d_idx == IDX_STAT) |=> (stat & $past(stat)) == $past(stat))
    else $error("status lost without a read");
  a_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    rd && d_idx == IDX_STAT && ev_vec == '0 |=> stat == '0)
    else $error("status read did not clear");
  a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    ev_vec != '0 |=> (stat & $past(ev_vec)) == $past(ev_vec))
    else $error("event lost against clear");
  a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take |=> !hreadyout ##1 hreadyout)
    else $error("transfer timing wrong");
  a_ch2_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    !src_m[1] && !sd_en[1] && mode_r[B_CMPSEL] |-> ch_mode[1] == TSMI_CMP)
    else $error("channel 2 not in comparator mode");
  a_ch2_two: assert property (@(posedge hclk) disable iff (!hresetn)
    !src_m[1] && !sd_en[1] && !mode_r[B_CMPSEL] |-> ch_mode[1] == TSMI_TWO)
    else $error("channel 2 not in two-times mode");
  a_ch1_shut: assert property (@(posedge hclk) disable iff (!hresetn)
    !src_m[0] && sd_en[0] |-> ch_mode[0] == (sd_m[0] ? TSMI_OFF : TSMI_TWO))
    else $error("channel 1 shutdown decode wrong");
  a_ch1_one: assert property (@(posedge hclk) disable iff (!hresetn)
    !src_m[0] && !sd_en[0] && scan_lim[15:8] != HYST_CMP && mode_r[B_ONESHOT]
    |-> ch_mode[0] == TSMI_ONE)
    else $error("channel 1 one-time decode wrong");

endmodule : tsmi_ctrl

/* testbench/tsmi_host.sv */
// Host side model: counts interrupt requests seen on the active-low line.
// Assumes the line is driven on hclk by the block under test.
`timescale 1ns/1ps
module tsmi_host
  import tsmi_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic mgmt_interrupt_n,
  output int        req_count
);
  logic line_q;

  // counts request edges
  // One request per falling edge of the line
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      line_q    <= 1'b1;
      req_count <= 0;
    end
    else
    begin
      line_q <= mgmt_interrupt_n;
      if (line_q && !mgmt_interrupt_n)
        req_count <= req_count + 1;
    end
endmodule : tsmi_host

/* testbench/tb.sv */
// Testbench of the temperature interrupt controller.
// Assumes tsmi_ctrl as the only bus slave and a host model on the interrupt line.
`timescale 1ns/1ps
module tb
  import tsmi_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, mgmt_interrupt_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [47:0] temp_reading;
  int          err_count, check_count, req_count, c0;

  // Clock of 8 ns
  always #4 hclk = ~hclk;

  // Block under test, bus ready looped back
  tsmi_ctrl u_tsmi_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .temp_reading(temp_reading),
    .irq(irq), .mgmt_interrupt_n(mgmt_interrupt_n));

  // Host interrupt input
  tsmi_host u_tsmi_host (.hclk(hclk), .hresetn(hresetn),
    .mgmt_interrupt_n(mgmt_interrupt_n), .req_count(req_count));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One single word transfer; read data land in rd
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    cmp(rd, exp);
  endtask : rc

  // Full scan of six channels plus status latency
  task automatic scan;
    repeat (16) @(negedge hclk);
  endtask : scan

  // Flush stale events, then empty the status register
  task automatic clr;
    scan();
    xfer(1'b0, IDX_STAT, 32'h0);
    scan();
  endtask : clr

  task automatic temp(input int ch, input logic [7:0] t);
    @(posedge hclk);
    temp_reading[ch*8 +: 8] <= t;
    scan();
  endtask : temp

  task automatic all(input logic [7:0] t);
    @(posedge hclk);
    temp_reading <= {6{t}};
    scan();
  endtask : all

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    cmp({31'h0, mgmt_interrupt_n}, 32'h1);
    rc(IDX_STAT, 32'h0);
    rc(IDX_ARMED, 32'h3f);
    rc(IDX_LIM0, {16'h0, LIM_RST});
    rc(IDX_MODE, {24'h0, REG_RST});
    rc(8'h10, 32'h0);
    $display("done reset values");
  endtask : t_reset

  task automatic t_two;
    c0 = req_count;
    wr(IDX_LIM0 + 8'd1, 32'h2832);
    temp(1, 8'h3c);
    cmp({30'h0, irq, mgmt_interrupt_n}, 32'h2);
    rc(IDX_ARMED, 32'h3d);
    rc(IDX_STAT, 32'h2);
    rc(IDX_STAT, 32'h0);
    scan();
    rc(IDX_STAT, 32'h0);
    temp(1, 8'h1e);
    rc(IDX_STAT, 32'h2);
    rc(IDX_ARMED, 32'h3f);
    cmp(req_count - c0, 32'h2);
    $display("done two-times mode");
  endtask : t_two

  task automatic t_cmp;
    c0 = req_count;
    wr(IDX_MODE, 32'h40);
    wr(IDX_LIM0 + 8'd2, 32'h2832);
    temp(2, 8'h3c);
    scan();
    cmp(req_count - c0, 32'h1);
    rc(IDX_STAT, 32'h4);
    scan();
    rc(IDX_STAT, 32'h4);
    temp(2, 8'h2d);
    clr();
    rc(IDX_STAT, 32'h4);
    temp(2, 8'h1e);
    clr();
    rc(IDX_STAT, 32'h0);
    wr(IDX_MODE, 32'h0);
    $display("done comparator mode");
  endtask : t_cmp

  task automatic t_ch1;
    clr();
    wr(IDX_LIM0, 32'h2832);
    wr(IDX_MODE, 32'h20);
    temp(0, 8'h3c);
    rc(IDX_STAT, 32'h1);
    temp(0, 8'h1e);
    rc(IDX_STAT, 32'h0);
    wr(IDX_CH1_HYST, {24'h0, HYST_CMP});
    temp(0, 8'h3c);
    clr();
    rc(IDX_STAT, 32'h1);
    rc(IDX_LIM0, 32'h7f32);
    rc(IDX_CH1_HYST, {24'h0, HYST_CMP});
    wr(IDX_LIM0, 32'h2832);
    wr(IDX_MODE, 32'h0);
    temp(0, 8'h0);
    $display("done channel one modes");
  endtask : t_ch1

  task automatic t_shut;
    clr();
    for (int i = 0; i < 6; i++)
      wr(IDX_LIM0 + 8'(i), 32'h2832);
    wr(IDX_SD_EN, 32'h70);
    wr(IDX_EXT_EN, 32'h7);
    all(8'h3c);
    rc(IDX_STAT, 32'h3f);
    scan();
    rc(IDX_STAT, 32'h0);
    all(8'h1e);
    rc(IDX_STAT, 32'h3f);
    wr(IDX_SHUT, 32'h38);
    wr(IDX_EXT_MSK, 32'h38);
    all(8'h3c);
    clr();
    rc(IDX_STAT, 32'h0);
    wr(IDX_SRC_A, 32'h30);
    wr(IDX_SRC_B, 32'h20);
    wr(IDX_EXT_MSK, 32'h7);
    wr(IDX_SHUT, 32'h0);
    clr();
    rc(IDX_STAT, 32'h0);
    all(8'h0);
    wr(IDX_SRC_A, 32'h0);
    $display("done shutdown and masks");
  endtask : t_shut

  task automatic t_mask;
    clr();
    wr(IDX_IMASK, 32'h2);
    temp(1, 8'h3c);
    cmp({30'h0, irq, mgmt_interrupt_n}, 32'h1);
    wr(IDX_IMASK, 32'h0);
    repeat (3) @(negedge hclk);
    cmp({30'h0, irq, mgmt_interrupt_n}, 32'h2);
    wr(IDX_STAT, 32'h2);
    repeat (3) @(negedge hclk);
    cmp({30'h0, irq, mgmt_interrupt_n}, 32'h1);
    cmp({31'h0, hresp}, 32'h0);
    $display("done interrupt mask");
  endtask : t_mask

  // Cuts a hung run short
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_count++;
    $display("FAIL t=%0t watchdog expired", $time);
    conclude();
  end

  // Reset, then the scenarios in turn
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    temp_reading = 48'h0;
    err_count = 0;
    check_count = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    t_reset();
    t_two();
    t_cmp();
    t_ch1();
    t_shut();
    t_mask();
    conclude();
  end
endmodule : tb
